// File: rtl/irq_rerouter_params.svh
// constants and the register map for the pci interrupt rerouter
`ifndef IRQ_REROUTER_PARAMS_SVH
`define IRQ_REROUTER_PARAMS_SVH
`define ADDR_ROUTE_LO      32'h0000_0000
`define ADDR_ROUTE_HI      32'h0000_0004
`define ADDR_ALIAS_LO      32'h0000_0008
`define ADDR_ALIAS_HI      32'h0000_000c
`define ADDR_ERR_CTRL      32'h0000_0010
`define ADDR_INT_STATUS    32'h0000_0014
`define ADDR_INT_MASK      32'h0000_0018
`define ADDR_LINE_STATE    32'h0000_001c
`define ROUTE_RESET        8'h00
`define ERR_CTRL_RESET     8'h00
`define INT_MASK_RESET     8'h00
`define ERR_CTRL_SMI_EN    0
`define ERR_CTRL_NMI_EN    1
`define ERR_CTRL_FORCE_NMI 2
`define STAT_ERR_SMI       4
`define STAT_ERR_NMI       5
`define NUM_PCI_LINES      4
`define NUM_ISA_IRQ        8
`endif

// File: rtl/irq_rerouter_pkg.sv
// types shared by the pci interrupt rerouter
package irq_rerouter_pkg;
    // nibble code: 0..7 pass-through, 8..15 select isa irq (code - 8)
    typedef logic [3:0] route_code_t;

    // incoming pci interrupt sources, active low as on the bus
    typedef struct packed {
        logic       slot_inta_n_unused;
        logic [3:0] slot_inta_n;
        logic       nic_inta_n;
        logic [2:0] cascade_n;
    } pci_src_s;

    // error sources feeding the nmi/smi logic
    typedef struct packed {
        logic err_hub;
        logic err_mgmt;
        logic err_fatal;
    } err_src_s;

    // register access state for the apb slave
    typedef enum logic [2:0] {
        BUS_IDLE   = 3'b001,
        BUS_ACCESS = 3'b010,
        BUS_DONE   = 3'b100
    } bus_state_e;
endpackage

// File: rtl/pci_irq_rerouter.sv
// pci to isa interrupt rerouter with apb registers and nmi/smi error steering
`timescale 1ns/1ps
`include "irq_rerouter_params.svh"
module pci_irq_rerouter (
    // clock and reset
    input  wire  logic                         CLK_SYS,
    input  wire  logic                         RST,
    // apb register port
    input  wire  logic                         PSEL,
    input  wire  logic                         PENABLE,
    input  wire  logic                         PWRITE,
    input  wire  logic [31:0]                  PADDR,
    input  wire  logic [31:0]                  PWDATA,
    output logic       [31:0]                  PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    // pci interrupt sources, active low
    input  wire  irq_rerouter_pkg::pci_src_s   PCI_SRC,
    // error sources, active high
    input  wire  irq_rerouter_pkg::err_src_s   ERR_SRC,
    // interrupt destinations
    output logic       [3:0]                   APIC_IRQ_INPUT,
    output logic       [7:0]                   ISA_IRQ,
    output logic                               CPU_NMI,
    output logic                               SYS_MGMT_IRQ_N,
    output logic                               IRQ_OUT
);
    import irq_rerouter_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  route_lo;      // nibbles for lines a (low) and b
    logic [7:0]  route_hi;      // nibbles for lines c (low) and d
    logic [7:0]  err_ctrl;
    logic [7:0]  int_status;
    logic [7:0]  int_mask;
    logic [3:0]  line_req;      // merged pci requests, active high
    logic [3:0]  line_prev;
    logic        wr_en;
    logic        rd_en;
    logic [4:0]  reg_sel;
    logic [3:0]  next_apic;
    logic [7:0]  next_isa;
    logic        err_any;
    logic        err_nmi;
    logic        err_smi;
    logic [7:0]  next_status;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: access phase with one wait state
    assign wr_en   = PSEL && PENABLE && PWRITE && PREADY;
    assign rd_en   = PSEL && PENABLE && !PWRITE;
    assign reg_sel = PADDR[4:0];

    // pready is high one cycle into the access phase; answers after one wait state
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
        end
    end

    // routing writes; upper word pair aliases the lower, as byte offsets 2,3 do
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            route_lo <= `ROUTE_RESET;  // every nibble pass-through
            route_hi <= `ROUTE_RESET;
        end else if (wr_en && PADDR[31:4] == 28'h0) begin
            if (PADDR[2] == 1'b0) begin
                route_lo <= PWDATA[7:0];
            end else begin
                route_hi <= PWDATA[7:0];
            end
        end
    end

    // error control and mask writes
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            err_ctrl <= `ERR_CTRL_RESET;
            int_mask <= `INT_MASK_RESET;
        end else if (wr_en) begin
            if (PADDR == `ADDR_ERR_CTRL) begin
                err_ctrl <= PWDATA[7:0];
            end
            if (PADDR == `ADDR_INT_MASK) begin
                int_mask <= PWDATA[7:0];
            end
        end
    end

    // read mux; unmapped addresses read zero and flag an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_sel)
            5'h00, 5'h08: next_rdata = {24'h000000, route_lo};
            5'h04, 5'h0c: next_rdata = {24'h000000, route_hi};
            5'h10:        next_rdata = {24'h000000, err_ctrl};
            5'h14:        next_rdata = {24'h000000, int_status};
            5'h18:        next_rdata = {24'h000000, int_mask};
            5'h1c:        next_rdata = {28'h0000000, line_req};
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    // read data and slave error are registered with pready
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            // reg_sel drops the upper address bits, so out-of-window reads are gated here
            PRDATA  <= (rd_en && !PREADY && PADDR[31:5] == 27'h0) ? next_rdata : 32'h0000_0000;
            PSLVERR <= PSEL && PENABLE && !PREADY && (PADDR[31:5] != 27'h0 || PADDR[1:0] != 2'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source merge: each slot's inta plus cascade and on-board devices
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            line_req <= 4'h0;
        end else begin
            // line a: slot inta pins and nic; b..d: cascaded swizzle incl. scsi
            line_req[0] <= ~(&PCI_SRC.slot_inta_n) | ~PCI_SRC.nic_inta_n;
            line_req[1] <= ~PCI_SRC.cascade_n[0];
            line_req[2] <= ~PCI_SRC.cascade_n[1];
            line_req[3] <= ~PCI_SRC.cascade_n[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing: each nibble acts alone on its own line
    always_comb begin
        route_code_t code;
        code      = 4'h0;
        next_apic = 4'h0;
        next_isa  = 8'h00;
        for (int i = 0; i < `NUM_PCI_LINES; i++) begin
            code = (i < 2) ? route_lo[4*i +: 4] : route_hi[4*(i-2) +: 4];
            if (code[3] == 1'b0) begin
                next_apic[i] = line_req[i];  // line i to apic 16+i
            end else begin
                // isa outputs only carry rerouted lines
                next_isa[code[2:0]] = next_isa[code[2:0]] | line_req[i];
            end
        end
    end

    // interrupt outputs straight from flops
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            APIC_IRQ_INPUT <= 4'h0;
            ISA_IRQ        <= 8'h00;
        end else begin
            APIC_IRQ_INPUT <= next_apic;
            ISA_IRQ        <= next_isa;   // bit order irq 3,4,5,7,10,11,12,15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error steering: smi when enabled, else nmi; fatal always nmi, but cpu_nmi only while its enable is set
    assign err_any = ERR_SRC.err_hub | ERR_SRC.err_mgmt | ERR_SRC.err_fatal;
    assign err_smi = err_any && err_ctrl[`ERR_CTRL_SMI_EN];
    assign err_nmi = ERR_SRC.err_fatal ||
                     (err_any && !err_ctrl[`ERR_CTRL_SMI_EN]) ||
                     err_ctrl[`ERR_CTRL_FORCE_NMI];

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CPU_NMI        <= 1'b0;
            SYS_MGMT_IRQ_N <= 1'b1;
        end else begin
            CPU_NMI        <= err_nmi && err_ctrl[`ERR_CTRL_NMI_EN];
            SYS_MGMT_IRQ_N <= !err_smi;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status: rising request edges and error deliveries; set beats clear
    always_comb begin
        next_status = int_status;
        if (wr_en && PADDR == `ADDR_INT_STATUS) begin
            next_status = int_status & ~PWDATA[7:0];
        end
        next_status[3:0] = next_status[3:0] | (line_req & ~line_prev);
        next_status[`STAT_ERR_SMI] = next_status[`STAT_ERR_SMI] | err_smi;
        next_status[`STAT_ERR_NMI] = next_status[`STAT_ERR_NMI] |
                                     (err_nmi && err_ctrl[`ERR_CTRL_NMI_EN]);
        next_status[7:6] = 2'b00;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            int_status    <= 8'h00;
            line_prev     <= 4'h0;
            IRQ_OUT       <= 1'b0;
        end else begin
            int_status    <= next_status;
            line_prev     <= line_req;
            IRQ_OUT       <= |(next_status & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_pass_through: assert property (@(posedge CLK_SYS) disable iff (RST)
        (route_lo[3:0] == 4'h0 && $stable(route_lo)) |=> APIC_IRQ_INPUT[0] == $past(line_req[0]))
        else $error("line a not passed to apic");
    a_steer_isa: assert property (@(posedge CLK_SYS) disable iff (RST)
        (route_hi[7] && line_req[3]) |=> ISA_IRQ[$past(route_hi[6:4])])
        else $error("line d not steered");
    a_steer_no_apic: assert property (@(posedge CLK_SYS) disable iff (RST)
        route_lo[7] |=> !APIC_IRQ_INPUT[1])
        else $error("steered line still on apic");
    a_route_write: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_en && PADDR == `ADDR_ALIAS_LO) |=> route_lo == $past(PWDATA[7:0]))
        else $error("alias write missed");
    a_reset_pass: assert property (@(posedge CLK_SYS)
        $past(RST) |-> route_lo == 8'h00 && route_hi == 8'h00)
        else $error("route not pass-through after reset");
    a_smi_route: assert property (@(posedge CLK_SYS) disable iff (RST)
        (err_any && err_ctrl[0]) |=> !SYS_MGMT_IRQ_N)
        else $error("error not routed to smi");
    a_fatal_nmi: assert property (@(posedge CLK_SYS) disable iff (RST)
        (ERR_SRC.err_fatal && err_ctrl[1]) |=> CPU_NMI)
        else $error("fatal error without nmi");
    a_nmi_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
        (ERR_SRC.err_hub && !err_ctrl[0] && err_ctrl[1]) |=> CPU_NMI && SYS_MGMT_IRQ_N)
        else $error("direct nmi missing");
    a_apb_ready: assert property (@(posedge CLK_SYS) disable iff (RST)
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("apb answer late");
    c_steer: cover property (@(posedge CLK_SYS) disable iff (RST) |ISA_IRQ);
    c_smi: cover property (@(posedge CLK_SYS) disable iff (RST) !SYS_MGMT_IRQ_N);
    c_irq: cover property (@(posedge CLK_SYS) disable iff (RST) IRQ_OUT);
    c_pass: cover property (@(posedge CLK_SYS) disable iff (RST) |APIC_IRQ_INPUT);
    c_nmi: cover property (@(posedge CLK_SYS) disable iff (RST) CPU_NMI);

    ////////////////////////////////////////////////////////////////////////////
    // further checks: register map, routing of the upper lines, status and errors

    // with every nibble in pass-through nothing may leak onto the isa side
    a_isa_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
        (route_lo == 8'h00 && route_hi == 8'h00) |=> ISA_IRQ == 8'h00)
        else $error("isa output raised while all lines pass through");

    // line c passes to apic 18 when its nibble is pass-through
    a_pass_line_c: assert property (@(posedge CLK_SYS) disable iff (RST)
        (route_hi[3:0] == 4'h0 && $stable(route_hi)) |=> APIC_IRQ_INPUT[2] == $past(line_req[2]))
        else $error("line c not passed to apic");

    // a steered line d must leave its apic input alone
    a_steer_d_off: assert property (@(posedge CLK_SYS) disable iff (RST)
        route_hi[7] |=> !APIC_IRQ_INPUT[3])
        else $error("steered line d still on apic");

    // direct write of the upper routing byte
    a_hi_write: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_en && PADDR == `ADDR_ROUTE_HI) |=> route_hi == $past(PWDATA[7:0]))
        else $error("route hi write missed");

    // alias of the upper routing byte lands in the same register
    a_alias_hi: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_en && PADDR == `ADDR_ALIAS_HI) |=> route_hi == $past(PWDATA[7:0]))
        else $error("alias hi write missed");

    // low address bits pick the register on a read of the alias
    a_reg_select: assert property (@(posedge CLK_SYS) disable iff (RST)
        (rd_en && !PREADY && PADDR == `ADDR_ALIAS_HI) |=> PRDATA == {24'h000000, $past(route_hi)})
        else $error("alias read returned wrong register");

    // reads beyond the window give zero and flag the error
    a_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
        (PSEL && PENABLE && !PREADY && PADDR[31:5] != 27'h0) |=> PRDATA == 32'h0 && PSLVERR)
        else $error("unmapped read not refused");

    // the nic has its own input, merged into line a
    a_nic_merge: assert property (@(posedge CLK_SYS) disable iff (RST)
        !PCI_SRC.nic_inta_n |=> line_req[0])
        else $error("nic request lost");

    // smi stays quiet while its enable is clear
    a_smi_off: assert property (@(posedge CLK_SYS) disable iff (RST)
        !err_ctrl[`ERR_CTRL_SMI_EN] |=> SYS_MGMT_IRQ_N)
        else $error("smi raised while disabled");

    // nmi is gated by its enable whatever the source
    a_nmi_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        !err_ctrl[`ERR_CTRL_NMI_EN] |=> !CPU_NMI)
        else $error("nmi raised while disabled");

    // every delivered nmi leaves a sticky mark for software
    a_nmi_status: assert property (@(posedge CLK_SYS) disable iff (RST)
        CPU_NMI |-> int_status[`STAT_ERR_NMI])
        else $error("nmi not recorded in status");

    // every delivered smi leaves a sticky mark for software
    a_smi_status: assert property (@(posedge CLK_SYS) disable iff (RST)
        !SYS_MGMT_IRQ_N |-> int_status[`STAT_ERR_SMI])
        else $error("smi not recorded in status");

    // the summary interrupt follows the masked status one-to-one
    a_irq_level: assert property (@(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> IRQ_OUT == |(int_status & $past(int_mask)))
        else $error("summary interrupt does not follow status");
endmodule // pci_irq_rerouter

// File: testbench/pci_source_model.sv
// model of the pci interrupt sources seen by the rerouter
`timescale 1ns/1ps
module pci_source_model
    import irq_rerouter_pkg::*;
(
    // requests: bits 0-3 slots, 4 nic, 5-7 cascade b,c,d
    input  wire logic [7:0] req,
    // open-drain lines towards the rerouter
    output pci_src_s        src
);
    ////////////////////////////////////////////////////////////////////////
    // each source has its own wire, so shared lines never fight
    // a released line floats to its pull-up, never to its last value
    always_comb begin
        src.slot_inta_n_unused = 1'b1;
        src.slot_inta_n        = ~req[3:0];
        src.nic_inta_n         = ~req[4];
        src.cascade_n          = ~req[7:5];
    end
endmodule // pci_source_model

// File: testbench/pci_irq_rerouter_test.sv
// self-checking bench for the pci interrupt rerouter
`timescale 1ns/1ps
`include "irq_rerouter_params.svh"
module pci_irq_rerouter_test;
    import irq_rerouter_pkg::*;
    typedef struct {logic [7:0] lo, hi, src; logic [3:0] apic, am; logic [7:0] isa;} row_s;
    logic        CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv_err;
    logic        CPU_NMI, SYS_MGMT_IRQ_N, IRQ_OUT;
    logic [31:0] PADDR, PWDATA, PRDATA, rd;
    logic [3:0]  APIC_IRQ_INPUT;
    logic [7:0]  ISA_IRQ, req;
    pci_src_s    PCI_SRC;
    err_src_s    ERR_SRC;
    int          fail_count, checked, cycles;
    // lo, hi, sources, apic expected, apic mask, isa expected
    row_s rows [7] = '{
        '{8'h00, 8'h00, 8'h10, 4'h1, 4'hf, 8'h00}, '{8'h00, 8'h00, 8'he0, 4'he, 4'hf, 8'h00},
        '{8'h08, 8'h00, 8'h01, 4'h0, 4'he, 8'h01}, '{8'hf0, 8'h00, 8'h21, 4'h1, 4'hd, 8'h80},
        '{8'h00, 8'h9a, 8'hc0, 4'h0, 4'h3, 8'h06}, '{8'h00, 8'h9a, 8'h40, 4'h0, 4'h3, 8'h04},
        '{8'h77, 8'h00, 8'h08, 4'h1, 4'hf, 8'h00}};

    pci_irq_rerouter u_dut (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .PCI_SRC, .ERR_SRC, .APIC_IRQ_INPUT, .ISA_IRQ, .CPU_NMI,
        .SYS_MGMT_IRQ_N, .IRQ_OUT);
    pci_source_model u_src (.req(req), .src(PCI_SRC));

    ////////////////////////////////////////////////////////////////////////
    // 50 mhz clock and a hang guard sized well above the sequence length
    always #10 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks: comparison, apb transfer, test end, verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // waits for pready with no assumed latency; only the guard ends it
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        @(posedge CLK_SYS iff PREADY === 1'b1);
        rd = PRDATA;
        slv_err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // error steering case; status cleared afterwards so cases stay apart
    task automatic err_case(input logic [7:0] ctl, input err_src_s e, input logic nmi,
                            input logic smi_n);
        apb(1'b1, `ADDR_ERR_CTRL, {24'h0, ctl});
        ERR_SRC <= e;
        repeat (3) @(posedge CLK_SYS);
        check(CPU_NMI, nmi);
        check(SYS_MGMT_IRQ_N, smi_n);
        apb(1'b0, `ADDR_INT_STATUS, 32'h0);
        check(rd[5:4], {nmi, ~smi_n});
        ERR_SRC <= '0;
        repeat (3) @(posedge CLK_SYS);
        apb(1'b1, `ADDR_INT_STATUS, 32'hff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        CLK_SYS = 1'b0;  RST = 1'b1;  PSEL = 1'b0;  PENABLE = 1'b0;  PWRITE = 1'b0;
        PADDR = '0;  PWDATA = '0;  req = '0;  ERR_SRC = '0;
        fail_count = 0;  checked = 0;  cycles = 0;
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        check(ISA_IRQ, 8'h00);
        check(SYS_MGMT_IRQ_N, 1'b1);
        req <= 8'h01;
        repeat (3) @(posedge CLK_SYS);
        check(APIC_IRQ_INPUT, 4'h1);
        req <= 8'h00;
        apb(1'b0, `ADDR_ROUTE_HI, 32'h0);
        check(rd, 32'h0);
        done("reset");
        // routing rows: write lo and hi, drive the sources, check apic and isa
        foreach (rows[i]) begin
            apb(1'b1, `ADDR_ROUTE_LO, {24'h0, rows[i].lo});
            apb(1'b1, `ADDR_ROUTE_HI, {24'h0, rows[i].hi});
            req <= rows[i].src;
            repeat (3) @(posedge CLK_SYS);
            check(APIC_IRQ_INPUT & rows[i].am, rows[i].apic & rows[i].am);
            check(ISA_IRQ, rows[i].isa);
            req <= 8'h00;
            repeat (3) @(posedge CLK_SYS);
        end
        done("rows");
        // every isa output, reached by line a
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `ADDR_ROUTE_LO, 32'h8 + k);
            req <= 8'h01;
            repeat (3) @(posedge CLK_SYS);
            check(ISA_IRQ, 8'h01 << k);
            req <= 8'h00;
            repeat (3) @(posedge CLK_SYS);
        end
        done("isa codes");
        // aliases, upper bits dropped, unmapped read
        apb(1'b1, `ADDR_ALIAS_LO, 32'hffff_ff5a);
        apb(1'b0, `ADDR_ROUTE_LO, 32'h0);
        check(rd, 32'h5a);
        apb(1'b1, `ADDR_ROUTE_HI, 32'h3c);
        apb(1'b0, `ADDR_ALIAS_HI, 32'h0);
        check(rd, 32'h3c);
        apb(1'b0, 32'h20, 32'h0);
        check(rd, 32'h0);
        check(slv_err, 1'b1);
        done("registers");
        // interrupt raised, cleared, then masked
        apb(1'b1, `ADDR_ROUTE_LO, 32'h0);
        apb(1'b1, `ADDR_INT_STATUS, 32'hff);
        apb(1'b1, `ADDR_INT_MASK, 32'h01);
        req <= 8'h01;
        repeat (3) @(posedge CLK_SYS);
        check(IRQ_OUT, 1'b1);
        apb(1'b1, `ADDR_INT_STATUS, 32'h01);
        @(posedge CLK_SYS);
        check(IRQ_OUT, 1'b0);
        apb(1'b1, `ADDR_INT_MASK, 32'h00);
        req <= 8'h00;
        repeat (3) @(posedge CLK_SYS);
        req <= 8'h01;
        repeat (3) @(posedge CLK_SYS);
        check(IRQ_OUT, 1'b0);
        apb(1'b0, `ADDR_INT_STATUS, 32'h0);
        check(rd[0], 1'b1);
        req <= 8'h00;
        done("interrupt");
        err_case(8'h02, '{1'b1, 1'b0, 1'b0}, 1'b1, 1'b1);
        err_case(8'h03, '{1'b1, 1'b0, 1'b0}, 1'b0, 1'b0);
        err_case(8'h03, '{1'b0, 1'b0, 1'b1}, 1'b1, 1'b0);
        err_case(8'h01, '{1'b0, 1'b1, 1'b0}, 1'b0, 1'b0);
        err_case(8'h06, '{1'b0, 1'b0, 1'b0}, 1'b1, 1'b1);
        done("errors");
        // reset in mid-run returns routing to pass-through
        apb(1'b1, `ADDR_ROUTE_LO, 32'h88);
        RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        check(CPU_NMI, 1'b0);
        apb(1'b0, `ADDR_ROUTE_LO, 32'h0);
        check(rd, 32'h0);
        done("reset again");
        print_verdict();
    end
endmodule // pci_irq_rerouter_test
